// file: seq_stamp_defs.svh
`ifndef SEQ_STAMP_DEFS_SVH
`define SEQ_STAMP_DEFS_SVH

// register offsets, bank zero
`define OFS_CHAN7_STAMP_HIGH  8'h9C
`define OFS_CHAN7_STAMP_LOW   8'h9D
`define OFS_CHAN8_STAMP_HIGH  8'h9E
`define OFS_CHAN8_STAMP_LOW   8'h9F
`define OFS_PAGE_CHOICE       8'hF0

// field positions and reset values
`define PAGE_BIT              0
`define STAMP_RESET           16'h0000
`define PAGE_RESET            1'b0

// sequence control codes
`define SEQ_CODE_RISE         2'h1
`define SEQ_CODE_FALL         2'h2

// timebase: one stamp step in ns, clock period in ns
`define STAMP_STEP_NS         50000
`define MCLK_PERIOD_NS        50
`define STEP_CYCLES           (`STAMP_STEP_NS / `MCLK_PERIOD_NS)

`endif

// file: seq_stamp_pkg.sv
package seq_stamp_pkg;

  // sequence phase, one-hot
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_RISE = 3'b010,
    SEQ_FALL = 3'b100
  } seq_state_t;

  // one channel's comparator view, already synchronised
  typedef struct packed {
    logic above_uv;
    logic above_off;
  } chan_cmp_t;

  // register access request from the serial front end
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// file: stamp_tick_gen.sv
`timescale 1ns/10ps
`include "seq_stamp_defs.svh"

// divides mclk down to one pulse per stamp step
module stamp_tick_gen
  import seq_stamp_pkg::*;
(
  // clocking
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic clk_en,
  // control
  input  wire logic restart,
  // output
  output logic      tick
);

  localparam int STEP_CYC = `STEP_CYCLES;
  localparam logic [10:0] LAST = 11'(STEP_CYC - 1);

  logic [10:0] div_r;

  // restart zeroes the phase so a step is a full 50 us from trigger
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      div_r <= 11'h000;
      tick  <= 1'b0;
    end else if (clk_en) begin
      if (restart) begin
        div_r <= 11'h000;
        tick  <= 1'b0;
      end else if (div_r == LAST) begin
        div_r <= 11'h000;
        tick  <= 1'b1;
      end else begin
        div_r <= div_r + 11'h001;
        tick  <= 1'b0;
      end
    end
  end

endmodule // stamp_tick_gen

// file: seq_stamp_capture.sv
`timescale 1ns/10ps
`include "seq_stamp_defs.svh"

// What this block does
// - each channel stamp in two read-only bytes
// - capture sequence timer during triggered sequence
// - code 01: latch on rising undervolt crossing
// - code 10: latch on falling off crossing
// - timer advances once every 50 us
// - page bit 0 selects bank zero or one
module seq_stamp_capture
  import seq_stamp_pkg::*;
(
  // clocking
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  // sequence triggers, one-cycle pulses with code
  input  wire logic       seq_start,
  input  wire logic [1:0] seq_code,
  // comparator pins, channels 7 and 8
  input  wire logic [1:0] above_uv_pin,
  input  wire logic [1:0] above_off_pin,
  // register port from serial front end
  input  reg_req_t        req,
  // register answers
  output logic [7:0]      rdata,
  output logic            rvalid,
  output logic            bank_one
);

  seq_state_t  state_r;
  logic [15:0] timer_r;
  logic        tick;
  logic        restart;
  logic [1:0]  uv_m_r;
  logic [1:0]  uv_s_r;
  logic [1:0]  off_m_r;
  logic [1:0]  off_s_r;
  logic [1:0]  uv_d_r;
  logic [1:0]  off_d_r;
  logic [1:0]  done_r;
  logic [15:0] stamp_r [2];
  chan_cmp_t   cmp [2];
  logic        bank0;

  assign restart = seq_start && (seq_code == `SEQ_CODE_RISE || seq_code == `SEQ_CODE_FALL);
  assign bank0   = !bank_one;

  stamp_tick_gen u_tick (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .restart (restart),
    .tick    (tick)
  );

  // two-stage synchronisers on comparator pins
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      uv_m_r  <= 2'h0;
      uv_s_r  <= 2'h0;
      off_m_r <= 2'h0;
      off_s_r <= 2'h0;
    end else if (clk_en) begin
      uv_m_r  <= above_uv_pin;
      uv_s_r  <= uv_m_r;
      off_m_r <= above_off_pin;
      off_s_r <= off_m_r;
    end
  end

  // delayed copies for edge detection
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      uv_d_r  <= 2'h0;
      off_d_r <= 2'h0;
    end else if (clk_en) begin
      uv_d_r  <= uv_s_r;
      off_d_r <= off_s_r;
    end
  end

  // sequence phase
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_r <= SEQ_IDLE;
    end else if (clk_en && seq_start) begin
      case (seq_code)
        `SEQ_CODE_RISE: state_r <= SEQ_RISE;
        `SEQ_CODE_FALL: state_r <= SEQ_FALL;
        default:        state_r <= state_r;
      endcase
    end
  end

  // sequence timer, saturates so a late edge reads full scale
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      timer_r <= 16'h0000;
    end else if (clk_en) begin
      if (restart) begin
        timer_r <= 16'h0000;
      end else if (tick && state_r != SEQ_IDLE && timer_r != 16'hFFFF) begin
        timer_r <= timer_r + 16'h0001;
      end
    end
  end

  // per-channel capture, first crossing of the sequence only
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      logic hit;
      assign cmp[g].above_uv  = uv_s_r[g];
      assign cmp[g].above_off = off_s_r[g];
      always_comb begin
        hit = 1'b0;
        case (state_r)
          SEQ_RISE: hit = cmp[g].above_uv && !uv_d_r[g];
          SEQ_FALL: hit = !cmp[g].above_off && off_d_r[g];
          default:  hit = 1'b0;
        endcase
      end
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          stamp_r[g] <= `STAMP_RESET;
          done_r[g]  <= 1'b0;
        end else if (clk_en) begin
          if (restart) begin
            done_r[g] <= 1'b0;
          end else if (hit && !done_r[g]) begin
            stamp_r[g] <= timer_r;
            done_r[g]  <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // bank choice register, bit 0 only writable
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      bank_one <= `PAGE_RESET;
    end else if (clk_en && req.wr && req.addr == `OFS_PAGE_CHOICE) begin
      bank_one <= req.wdata[`PAGE_BIT];
    end
  end

  // read mux; stamp bytes ignore writes, other bank reads zero here
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else if (clk_en) begin
      rvalid <= req.rd;
      if (!req.rd) begin
        rdata <= 8'h00;
      end else if (req.addr == `OFS_PAGE_CHOICE) begin
        rdata <= {7'h00, bank_one};
      end else if (bank0 && req.addr == `OFS_CHAN7_STAMP_HIGH) begin
        rdata <= stamp_r[0][15:8];
      end else if (bank0 && req.addr == `OFS_CHAN7_STAMP_LOW) begin
        rdata <= stamp_r[0][7:0];
      end else if (bank0 && req.addr == `OFS_CHAN8_STAMP_HIGH) begin
        rdata <= stamp_r[1][15:8];
      end else if (bank0 && req.addr == `OFS_CHAN8_STAMP_LOW) begin
        rdata <= stamp_r[1][7:0];
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  // checks
  sequence rise_edge_s(int c);
    clk_en && state_r == SEQ_RISE && uv_s_r[c] && !uv_d_r[c] && !done_r[c] && !restart;
  endsequence

  rise_capture_a: assert property (@(posedge mclk) disable iff (!rst_b)
    rise_edge_s(0) |=> stamp_r[0] == $past(timer_r))
    else $error("rising crossing not captured");

  fall_capture_a: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && state_r == SEQ_FALL && !off_s_r[1] && off_d_r[1] && !done_r[1] && !restart
    |=> stamp_r[1] == $past(timer_r))
    else $error("falling crossing not captured");

  timer_restart_a: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && restart |=> timer_r == 16'h0000)
    else $error("timer not restarted");

  timer_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && !tick && !restart |=> timer_r == $past(timer_r))
    else $error("timer moved without a step");

  stamp_stable_a: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && req.wr && req.addr >= `OFS_CHAN7_STAMP_HIGH && req.addr <= `OFS_CHAN8_STAMP_LOW && !g_chan[0].hit
    |=> stamp_r[0] == $past(stamp_r[0]))
    else $error("stamp changed by host write");

  page_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && req.wr && req.addr == `OFS_PAGE_CHOICE |=> bank_one == $past(req.wdata[0]))
    else $error("page bit not written");

  read_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && req.rd && bank0 && req.addr == `OFS_CHAN8_STAMP_LOW |=> rvalid && rdata == $past(stamp_r[1][7:0]))
    else $error("low byte read wrong");

  idle_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && state_r == SEQ_IDLE && !restart |=> stamp_r[0] == $past(stamp_r[0]))
    else $error("capture outside a sequence");

  // a due step inside a sequence, below full scale
  sequence step_due_s;
    clk_en && tick && !restart && state_r != SEQ_IDLE && timer_r != 16'hFFFF;
  endsequence

  timer_step_a: assert property (@(posedge mclk) disable iff (!rst_b)
    step_due_s |=> timer_r == $past(timer_r) + 16'h0001)
    else $error("timer missed a step");

  freeze_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !clk_en |=> bank_one == $past(bank_one) && timer_r == $past(timer_r) && stamp_r[1] == $past(stamp_r[1]))
    else $error("state moved while frozen");

endmodule // seq_stamp_capture

// file: host_model.sv
`timescale 1ns/10ps
// register host: one request per call, driven off the falling edge
module host_model
  import seq_stamp_pkg::*;
(
  // clocking
  input  wire logic       mclk,
  // register port
  output reg_req_t        req,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  initial req = '0;

  // write strobe for one cycle; idle fields flip so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge mclk);
    req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // read strobe; answer stands only the cycle after the taking edge, so grab it then
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge mclk);
    req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge mclk);
    v = rvalid;
    d = rdata;
    req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
  endtask
endmodule // host_model

// file: tb_top.sv
`timescale 1ns/10ps
`include "seq_stamp_defs.svh"
module tb_top;
  import seq_stamp_pkg::*;
  logic       mclk, rst_b, seq_start, rvalid, bank_one;
  logic       clk_en;
  logic [1:0] seq_code, above_uv_pin, above_off_pin;
  logic [7:0] rdata;
  reg_req_t   req;
  int         failures, checked;
  int         k0, k1, k2;
  logic [7:0] r;

  // clock, 50 ns period
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  seq_stamp_capture DUT (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .seq_start(seq_start),
    .seq_code(seq_code), .above_uv_pin(above_uv_pin), .above_off_pin(above_off_pin),
    .req(req), .rdata(rdata), .rvalid(rvalid), .bank_one(bank_one));
  host_model host (.mclk(mclk), .req(req), .rdata(rdata), .rvalid(rvalid));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // read with answer and data compared
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    check("rvalid", 8'h01, {7'h00, v});
    check("rdata", exp, d);
  endtask

  task automatic give_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // pin crosses mid-step so the expected count is k, away from step edges
  task automatic run_seq(input logic [1:0] code, input int ch, input int k);
    int d;
    d = k * `STEP_CYCLES + `STEP_CYCLES / 2;
    @(negedge mclk);
    seq_start = 1'b1;
    seq_code  = code;
    @(negedge mclk);
    seq_start = 1'b0;
    repeat (d - 1) @(negedge mclk);
    if (code == `SEQ_CODE_RISE) above_uv_pin[ch] = 1'b1;
    else above_off_pin[ch] = 1'b0;
    repeat (10) @(negedge mclk);
    rd_chk(`OFS_CHAN7_STAMP_HIGH + 8'(2 * ch), 8'(k >> 8));
    rd_chk(`OFS_CHAN7_STAMP_LOW + 8'(2 * ch), 8'(k));
  endtask

  // watchdog, well beyond the longest expected run
  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    give_verdict();
  end

  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    seq_start = 1'b0;
    seq_code = 2'h0;
    above_uv_pin = 2'h0;
    above_off_pin = 2'h3;
    failures = 0;
    checked = 0;
    void'($urandom(46445));
    k0 = 1 + $urandom % 5;
    k1 = 1 + $urandom % 5;
    k2 = 1 + $urandom % 5;
    r = 8'($urandom);
    repeat (8) @(negedge mclk);
    rst_b = 1'b1;
    // reset state of all stamp bytes and the page choice
    for (int a = 0; a < 4; a++) rd_chk(`OFS_CHAN7_STAMP_HIGH + 8'(a), 8'h00);
    rd_chk(`OFS_PAGE_CHOICE, 8'h00);
    // rise on ch7 then ch8; ch7 must keep its stamp across the restart
    run_seq(`SEQ_CODE_RISE, 0, k0);
    run_seq(`SEQ_CODE_RISE, 1, k1);
    rd_chk(`OFS_CHAN7_STAMP_LOW, 8'(k0));
    // fall on ch8 overwrites its stamp
    run_seq(`SEQ_CODE_FALL, 1, k2);
    // code 11 is ignored: no restart, so a second fall on ch8 is not taken
    @(negedge mclk);
    seq_start = 1'b1;
    seq_code  = 2'h3;
    @(negedge mclk);
    seq_start = 1'b0;
    above_off_pin[1] = 1'b1;
    repeat (10) @(negedge mclk);
    above_off_pin[1] = 1'b0;
    repeat (10) @(negedge mclk);
    rd_chk(`OFS_CHAN8_STAMP_LOW, 8'(k2));
    // stamps are read-only
    host.wr(`OFS_CHAN7_STAMP_LOW, ~8'(k0));
    rd_chk(`OFS_CHAN7_STAMP_LOW, 8'(k0));
    // bank one hides the stamps; bank zero brings them back
    host.wr(`OFS_PAGE_CHOICE, r | 8'h01);
    check("bank_one", 8'h01, {7'h00, bank_one});
    rd_chk(`OFS_PAGE_CHOICE, 8'h01);
    rd_chk(`OFS_CHAN8_STAMP_LOW, 8'h00);
    host.wr(`OFS_PAGE_CHOICE, r & 8'hFE);
    check("bank_one", 8'h00, {7'h00, bank_one});
    rd_chk(`OFS_CHAN8_STAMP_LOW, 8'(k2));
    // clock enable low freezes the page bit against a write
    clk_en = 1'b0;
    host.wr(`OFS_PAGE_CHOICE, 8'h01);
    check("bank_one frozen", 8'h00, {7'h00, bank_one});
    clk_en = 1'b1;
    // unmapped place reads zero
    rd_chk(8'h10, 8'h00);
    give_verdict();
  end
endmodule // tb_top
